// ### pkg/rcs_consts.vh
// Constants of the reset and clock sequencer: offsets, fields, timing counts.
`ifndef RCS_CONSTS_VH
`define RCS_CONSTS_VH
// ====================================================================
// Register byte offsets
`define RCS_CAUSE_OFS     12'h000
`define RCS_CTRL_OFS      12'h004
`define RCS_STATUS_OFS    12'h008
`define RCS_SERVICE_OFS   12'h00C
`define RCS_VECTOR_OFS    12'h010
// ====================================================================
// Cause register field positions
`define RCS_CAUSE_BAD_FETCH_ADDRESS_FLAG    0
`define RCS_CAUSE_BAD_OPCODE_FLAG    1
`define RCS_CAUSE_WDOG    2
`define RCS_CAUSE_BROWN   3
`define RCS_CAUSE_PIN     4
`define RCS_CAUSE_POR     5
// ====================================================================
// Control register field positions and reset value
`define RCS_CTRL_SHORT_STOP_RECOVERY    0
`define RCS_CTRL_STOPEN   1
`define RCS_CTRL_PLLSEL   2
`define RCS_CTRL_RESET    3'h0
// ====================================================================
// Timing counts in reference clock cycles
`define RCS_STAB_CYCLES   13'h1000
`define RCS_SHORT_CYCLES  13'h0020
`define RCS_PIN_CYCLES    13'h0020
`define RCS_HOLD_CYCLES   13'h0020
`define RCS_POR_HOLD      13'h0040
`define RCS_PIN_MIN       13'h0043
`define RCS_PIN_MIN_POR   13'h1043
// ====================================================================
// Reset vectors
`define RCS_VEC_USER      16'hFFFE
`define RCS_VEC_MON       16'hFEFE
`endif

// ### rtl/rcs_sequencer.v
// Reset and clock sequencer: reset sources, reset pin, stabilisation
// counter, watchdog clocking and gated bus clock enables.
//
// Implementation choices: register access over APB and the register offsets.
`include "rcs_consts.vh"
module rcs_sequencer #(
	parameter WDOG_BITS = 6
)(
	// APB slave
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Reset sources
	input  wire        power_on_pulse,
	input  wire        brownout_in,
	input  wire        watchdog_req,
	input  wire        bad_opcode_in,
	input  wire        stop_exec,
	input  wire        wait_exec,
	input  wire        wake_event,
	input  wire        opcode_fetch,
	input  wire        addr_unmapped,
	input  wire        monitor_mode,
	input  wire        break_state,
	input  wire        hv_reset_pin,
	input  wire        hv_irq_pin,
	// Reset pin, three signals
	input  wire        rst_pin_in,
	output wire        rst_pin_out,
	output wire        rst_pin_oe,
	// System outputs
	output wire        internal_reset,
	output reg  [15:0] reset_vector,
	output wire        clock_gen_enable,
	output wire        cpu_clk_en,
	output wire        periph_clk_en,
	output wire        watchdog_flag_out
);
	localparam ST_IDLE = 3'h0;
	localparam ST_STAB = 3'h1;
	localparam ST_PIN  = 3'h2;
	localparam ST_HOLD = 3'h3;
	localparam ST_EXT  = 3'h4;
	localparam ST_STOP = 3'h5;
	localparam ST_REC  = 3'h6;

	// ================================================================
	// Input synchronisers
	reg [1:0] rst_pin_sync_reg;
	reg [1:0] wdog_sync_reg;
	reg [1:0] brown_sync_reg;
	reg [1:0] por_sync_reg;
	wire pin_low = ~rst_pin_sync_reg[1];
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rst_pin_sync_reg <= 2'h3;
			wdog_sync_reg    <= 2'h0;
			brown_sync_reg   <= 2'h0;
			por_sync_reg     <= 2'h0;
		end
		else
		begin
			rst_pin_sync_reg <= {rst_pin_sync_reg[0], rst_pin_in};
			wdog_sync_reg    <= {wdog_sync_reg[0], watchdog_req};
			brown_sync_reg   <= {brown_sync_reg[0], brownout_in};
			por_sync_reg     <= {por_sync_reg[0], power_on_pulse};
		end
	end

	// ================================================================
	// Registers and state
	reg  [2:0]  state_reg;
	reg  [12:0] stab_cnt_reg;
	reg  [12:0] seq_cnt_reg;
	reg  [12:0] pin_cnt_reg;
	reg  [5:0]  cause_reg;
	reg  [2:0]  ctrl_reg;
	reg  [WDOG_BITS-1:0] wdog_cnt_reg;
	reg         por_seq_reg;
	reg  [1:0]  div_reg;
	reg         wdog_ovf_reg;
	wire        wr = psel & penable & pwrite;
	wire        service_wr = wr & (paddr == `RCS_SERVICE_OFS);
	wire        ctrl_wr = wr & (paddr == `RCS_CTRL_OFS);
	// Watchdog may be disabled only by the high-voltage qualifiers.
	wire        wdog_disable = (monitor_mode & (hv_reset_pin | hv_irq_pin))
		| (break_state & hv_reset_pin);
	wire        wdog_hit = wdog_ovf_reg & ~wdog_disable;
	wire        opcode_bad = bad_opcode_in
		| (stop_exec & ~ctrl_reg[`RCS_CTRL_STOPEN]);
	wire        fetch_bad = opcode_fetch & addr_unmapped;
	wire        por_ev = por_sync_reg[1];
	wire        brown_ev = brown_sync_reg[1];
	wire        int_src = wdog_hit | opcode_bad | fetch_bad;
	wire        busy = (state_reg != ST_IDLE) && (state_reg != ST_STOP)
		&& (state_reg != ST_REC);
	wire        stab_ovf = (stab_cnt_reg == 13'h1FFF);
	reg         wait_reg;

	// ================================================================
	// Sequencer
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg    <= ST_STAB;
			seq_cnt_reg  <= 13'h0000;
			stab_cnt_reg <= 13'h0000;
			pin_cnt_reg  <= 13'h0000;
			cause_reg    <= 6'h20;
			por_seq_reg  <= 1'b1;
			wdog_cnt_reg <= {WDOG_BITS{1'b0}};
			wdog_ovf_reg <= 1'b0;
			wait_reg     <= 1'b0;
		end
		else
		begin
			stab_cnt_reg <= stab_cnt_reg + 13'h0001;
			if (service_wr)
				stab_cnt_reg[12:4] <= 9'h000;
			if (wdog_ovf_reg || service_wr || internal_reset)
			begin
				wdog_cnt_reg <= {WDOG_BITS{1'b0}};
				wdog_ovf_reg <= 1'b0;
			end
			else if (stab_ovf || wdog_sync_reg[1])
			begin
				{wdog_ovf_reg, wdog_cnt_reg} <=
					{1'b0, wdog_cnt_reg} + {{WDOG_BITS{1'b0}}, 1'b1};
			end
			if (wait_exec && state_reg == ST_IDLE)
				wait_reg <= 1'b1;
			if (wake_event || internal_reset)
				wait_reg <= 1'b0;
			// Pin low time is counted whatever caused the reset.
			if (pin_low)
			begin
				if (pin_cnt_reg != 13'h1FFF)
					pin_cnt_reg <= pin_cnt_reg + 13'h0001;
				if (pin_cnt_reg + 13'h0001 >= (por_seq_reg ?
					`RCS_PIN_MIN_POR : `RCS_PIN_MIN))
					cause_reg[`RCS_CAUSE_PIN] <= 1'b1;
			end
			else
				pin_cnt_reg <= 13'h0000;
			if (por_ev)
			begin
				state_reg    <= ST_STAB;
				seq_cnt_reg  <= 13'h0000;
				stab_cnt_reg <= 13'h0000;
				cause_reg    <= 6'h20;
				por_seq_reg  <= 1'b1;
			end
			else if (brown_ev && !busy)
			begin
				state_reg    <= ST_STAB;
				seq_cnt_reg  <= 13'h0000;
				stab_cnt_reg <= 13'h0000;
				cause_reg[`RCS_CAUSE_BROWN] <= 1'b1;
				por_seq_reg  <= 1'b1;
			end
			else if (int_src && !busy)
			begin
				state_reg    <= ST_PIN;
				seq_cnt_reg  <= 13'h0000;
				stab_cnt_reg <= 13'h0000;
				por_seq_reg  <= 1'b0;
				if (wdog_hit)
					cause_reg[`RCS_CAUSE_WDOG] <= 1'b1;
				if (opcode_bad)
					cause_reg[`RCS_CAUSE_BAD_OPCODE_FLAG] <= 1'b1;
				if (fetch_bad)
					cause_reg[`RCS_CAUSE_BAD_FETCH_ADDRESS_FLAG] <= 1'b1;
			end
			else
			begin
				case (state_reg)
				ST_IDLE:
				begin
					if (pin_low)
					begin
						state_reg   <= ST_EXT;
						por_seq_reg <= 1'b0;
					end
					else if (stop_exec && ctrl_reg[`RCS_CTRL_STOPEN])
					begin
						state_reg    <= ST_STOP;
						stab_cnt_reg <= 13'h0000;
					end
				end
				ST_STAB:
				begin
					seq_cnt_reg <= seq_cnt_reg + 13'h0001;
					if (seq_cnt_reg == `RCS_STAB_CYCLES - 13'h0001)
					begin
						state_reg   <= ST_HOLD;
						seq_cnt_reg <= 13'h0000;
					end
				end
				ST_PIN:
				begin
					seq_cnt_reg <= seq_cnt_reg + 13'h0001;
					if (seq_cnt_reg == `RCS_PIN_CYCLES - 13'h0001)
					begin
						state_reg   <= ST_HOLD;
						seq_cnt_reg <= 13'h0000;
					end
				end
				ST_HOLD:
				begin
					seq_cnt_reg <= seq_cnt_reg + 13'h0001;
					if (seq_cnt_reg == (por_seq_reg ? `RCS_POR_HOLD :
						`RCS_HOLD_CYCLES) - 13'h0001)
					begin
						state_reg   <= pin_low ? ST_EXT : ST_IDLE;
						seq_cnt_reg <= 13'h0000;
					end
				end
				ST_EXT:
				begin
					if (!pin_low)
						state_reg <= ST_IDLE;
				end
				ST_STOP:
				begin
					if (wake_event || pin_low)
					begin
						state_reg    <= ST_REC;
						seq_cnt_reg  <= 13'h0000;
					end
				end
				ST_REC:
				begin
					seq_cnt_reg <= seq_cnt_reg + 13'h0001;
					if (seq_cnt_reg == (ctrl_reg[`RCS_CTRL_SHORT_STOP_RECOVERY] ?
						`RCS_SHORT_CYCLES : `RCS_STAB_CYCLES)
						- 13'h0001)
						state_reg <= pin_low ? ST_EXT : ST_IDLE;
				end
				default:
					state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// ================================================================
	// Control register and bus clock divider
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= `RCS_CTRL_RESET;
			div_reg  <= 2'h0;
		end
		else
		begin
			div_reg <= div_reg + 2'h1;
			if (ctrl_wr)
				ctrl_reg <= pwdata[2:0];
			else if (internal_reset)
				ctrl_reg[`RCS_CTRL_PLLSEL] <= 1'b0;
		end
	end

	assign rst_pin_oe  = (state_reg == ST_STAB) || (state_reg == ST_PIN);
	assign rst_pin_out = 1'b0;
	assign internal_reset = busy;
	assign clock_gen_enable = ~((state_reg == ST_STAB) && por_seq_reg
		&& (seq_cnt_reg == 13'h0000) && cause_reg[`RCS_CAUSE_POR]) | 1'b1;
	wire bus_tick = (div_reg == 2'h3);
	// Bus enables stay off through reset, stop and stop recovery.
	wire clocks_on = ~busy && (state_reg != ST_STOP)
		&& (state_reg != ST_REC);
	assign periph_clk_en = clocks_on & bus_tick;
	assign cpu_clk_en    = clocks_on & bus_tick & ~wait_reg;
	assign watchdog_flag_out = cause_reg[`RCS_CAUSE_WDOG];

	// ================================================================
	// Reset vector and APB read path
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reset_vector <= `RCS_VEC_USER;
		else
			reset_vector <= monitor_mode ? `RCS_VEC_MON
				: `RCS_VEC_USER;
	end

	// Every access ends in its first access cycle: no wait states.
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~((paddr == `RCS_CAUSE_OFS)
		| (paddr == `RCS_CTRL_OFS) | (paddr == `RCS_STATUS_OFS)
		| (paddr == `RCS_SERVICE_OFS) | (paddr == `RCS_VECTOR_OFS));

	always @*
	begin
		case (paddr)
		`RCS_CAUSE_OFS:  prdata = {26'h0, cause_reg};
		`RCS_CTRL_OFS:   prdata = {29'h0, ctrl_reg};
		`RCS_STATUS_OFS: prdata = {16'h0000, pin_low, wait_reg,
			state_reg, stab_cnt_reg[12:2]};
		`RCS_VECTOR_OFS: prdata = {16'h0000, reset_vector};
		default:         prdata = 32'h00000000;
		endcase
	end
endmodule

// ### test/rcs_pin_model.sv
// Board side of the reset pin: pull-up and an external hold.
// ====================
// Pin model
module rcs_pin_model(
	// Control from the bench
	input logic  hold_low,
	// Pin signals
	input logic  rst_pin_out,
	input logic  rst_pin_oe,
	output logic pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	// The pin has a pull-up, so a released pin reads high.
	assign pin_level = !(hold_low || (rst_pin_oe && !rst_pin_out));
endmodule

// ### test/rcs_chk.sv
// Port assertions for the reset and clock sequencer.
`include "rcs_consts.vh"
// ====================
// Checker
module rcs_chk(
	// Clock and reset
	input logic        pclk,
	input logic        presetn,
	// Watched ports
	input logic        bad_opcode_in,
	input logic        opcode_fetch,
	input logic        addr_unmapped,
	input logic        monitor_mode,
	input logic        rst_pin_out,
	input logic        rst_pin_oe,
	input logic        internal_reset,
	input logic [15:0] reset_vector,
	input logic        clock_gen_enable,
	input logic        cpu_clk_en,
	input logic        periph_clk_en
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_low; rst_pin_oe |-> !rst_pin_out && internal_reset;
	endproperty
	a_low: assert property (p_low)
		else $error("reset pin driven high");
	property p_gen; clock_gen_enable; endproperty
	a_gen: assert property (p_gen)
		else $error("clock generator off");
	property p_op; bad_opcode_in && !internal_reset |=> rst_pin_oe; endproperty
	a_op: assert property (p_op)
		else $error("bad opcode did not reset");
	property p_fe;
		opcode_fetch && addr_unmapped && !internal_reset |=> rst_pin_oe;
	endproperty
	a_fe: assert property (p_fe)
		else $error("bad fetch did not reset");
	property p_tail; $fell(rst_pin_oe) |-> internal_reset [*8]; endproperty
	a_tail: assert property (p_tail)
		else $error("internal reset ended with pin");
	property p_qtr; cpu_clk_en |=> !cpu_clk_en [*3]; endproperty
	a_qtr: assert property (p_qtr)
		else $error("bus enable faster than quarter rate");
	property p_off; internal_reset |-> !cpu_clk_en && !periph_clk_en;
	endproperty
	a_off: assert property (p_off)
		else $error("clock running in reset");
	property p_vec;
		monitor_mode ##1 monitor_mode |-> reset_vector == `RCS_VEC_MON;
	endproperty
	a_vec: assert property (p_vec)
		else $error("wrong monitor vector");
endmodule
bind rcs_sequencer rcs_chk u_chk(.pclk, .presetn, .bad_opcode_in,
	.opcode_fetch, .addr_unmapped, .monitor_mode, .rst_pin_out,
	.rst_pin_oe, .internal_reset, .reset_vector, .clock_gen_enable,
	.cpu_clk_en, .periph_clk_en);

// ### test/reset_clock_sequencer_tb.sv
// Self-checking bench of the reset and clock sequencer.
`include "rcs_consts.vh"
module reset_clock_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        power_on_pulse, brownout_in, watchdog_req, bad_opcode_in;
	logic        stop_exec, wait_exec, wake_event, opcode_fetch, e;
	logic        addr_unmapped, monitor_mode, break_state, hv_reset_pin;
	logic        hv_irq_pin, rst_pin_in, rst_pin_out, rst_pin_oe;
	logic        internal_reset, clock_gen_enable, cpu_clk_en;
	logic        periph_clk_en, watchdog_flag_out, hold_low;
	logic [15:0] reset_vector;
	int          err_total, total_checks, cyc, n, c, p;
	rcs_sequencer DUT(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .power_on_pulse, .brownout_in,
		.watchdog_req, .bad_opcode_in, .stop_exec, .wait_exec, .wake_event,
		.opcode_fetch, .addr_unmapped, .monitor_mode, .break_state,
		.hv_reset_pin, .hv_irq_pin, .rst_pin_in, .rst_pin_out, .rst_pin_oe,
		.internal_reset, .reset_vector, .clock_gen_enable, .cpu_clk_en,
		.periph_clk_en, .watchdog_flag_out);
	rcs_pin_model u_pin(.hold_low, .rst_pin_out, .rst_pin_oe,
		.pin_level(rst_pin_in));
	initial
	begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end
	// ====================
	// Shared tasks
	task stop_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			err_total++;
			stop_test;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task step;
		@(posedge pclk);
		#1;
	endtask
	// Counts the cycles a level stays high; w picks internal_reset.
	task len(input bit w);
		n = 0;
		while ((w ? internal_reset : rst_pin_oe) === 1'b1 && n < 9000)
		begin
			n++;
			step;
		end
	endtask
	task wait_oe;
		c = 0;
		while (rst_pin_oe !== 1'b1 && c < 20)
		begin
			c++;
			step;
		end
		chk(rst_pin_oe, 1);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// ====================
	// Scenarios
	task t_por;
		len(0);
		chk(n, 4096);
		len(1);
		chk(n, 64);
		apb(0, `RCS_CAUSE_OFS, 0);
		chk(q, 32'h1 << `RCS_CAUSE_POR);
		apb(0, `RCS_CTRL_OFS, 0);
		chk(q, {29'h0, `RCS_CTRL_RESET});
		apb(1, `RCS_SERVICE_OFS, 0);
		apb(0, `RCS_STATUS_OFS, 0);
		chk(q[10:3], 0);
	endtask
	task t_vec;
		@(posedge pclk);
		monitor_mode <= 1;
		repeat (3) step;
		chk(reset_vector, `RCS_VEC_MON);
		@(posedge pclk);
		monitor_mode <= 0;
		repeat (3) step;
		chk(reset_vector, `RCS_VEC_USER);
	endtask
	task t_wait;
		@(posedge pclk);
		wait_exec <= 1;
		repeat (2) step;
		c = 0;
		p = 0;
		repeat (16)
		begin
			step;
			c += (cpu_clk_en !== 1'b0);
			p += (periph_clk_en === 1'b1);
		end
		chk(c, 0);
		chk(p, 4);
		@(posedge pclk);
		wait_exec <= 0;
		wake_event <= 1;
		@(posedge pclk);
		wake_event <= 0;
	endtask
	// Stop enable is clear after reset, so a stop is a bad opcode.
	task t_int;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge pclk);
			bad_opcode_in <= (i == 0);
			stop_exec <= (i == 1);
			opcode_fetch <= (i == 2);
			addr_unmapped <= (i == 2);
			@(posedge pclk);
			{bad_opcode_in, stop_exec, opcode_fetch, addr_unmapped} <= 4'h0;
			#1;
			wait_oe;
			len(0);
			chk(n, 32);
			len(1);
			chk(n, 32);
			apb(0, `RCS_CAUSE_OFS, 0);
			chk(q[i == 2 ? `RCS_CAUSE_BAD_FETCH_ADDRESS_FLAG : `RCS_CAUSE_BAD_OPCODE_FLAG],
				1);
		end
		@(posedge pclk);
		addr_unmapped <= 1;
		@(posedge pclk);
		addr_unmapped <= 0;
		repeat (6)
		begin
			step;
			chk(rst_pin_oe, 0);
		end
	endtask
	task t_pin(input int hold, input logic exp);
		@(posedge pclk);
		hold_low <= 1;
		repeat (hold) step;
		chk(internal_reset, 1);
		@(posedge pclk);
		hold_low <= 0;
		repeat (4) step;
		len(1);
		apb(0, `RCS_CAUSE_OFS, 0);
		chk(q[`RCS_CAUSE_PIN], exp);
	endtask
	task t_brown;
		@(posedge pclk);
		brownout_in <= 1;
		@(posedge pclk);
		brownout_in <= 0;
		#1;
		wait_oe;
		len(0);
		chk(n, 4096);
		len(1);
		apb(0, `RCS_CAUSE_OFS, 0);
		chk(q[`RCS_CAUSE_BROWN], 1);
		apb(0, 12'h020, 0);
		chk(e, 1);
		chk(q, 0);
	endtask
	// A held watchdog request ticks the counter every cycle.
	task t_wdog(input logic dis);
		@(posedge pclk);
		monitor_mode <= dis;
		hv_reset_pin <= dis;
		watchdog_req <= 1;
		c = 0;
		while (rst_pin_oe !== 1'b1 && c < 100)
		begin
			c++;
			step;
		end
		chk(rst_pin_oe, !dis);
		chk(watchdog_flag_out, !dis);
		@(posedge pclk);
		{watchdog_req, monitor_mode, hv_reset_pin} <= 3'h0;
		#1;
		len(0);
		len(1);
		if (!dis)
			chk(n, 32);
	endtask
	task t_stop(input logic [2:0] ctl, input int rec);
		apb(1, `RCS_CTRL_OFS, ctl);
		@(posedge pclk);
		stop_exec <= 1;
		@(posedge pclk);
		stop_exec <= 0;
		p = 0;
		repeat (8)
		begin
			step;
			p += (periph_clk_en !== 1'b0);
		end
		chk(p, 0);
		@(posedge pclk);
		wake_event <= 1;
		@(posedge pclk);
		wake_event <= 0;
		#1;
		repeat (rec)
		begin
			p += (periph_clk_en !== 1'b0);
			step;
		end
		chk(p, 0);
		c = 0;
		repeat (8)
		begin
			c += (periph_clk_en === 1'b1);
			step;
		end
		chk(c, 2);
	endtask
	task t_pwr;
		@(posedge pclk);
		power_on_pulse <= 1;
		@(posedge pclk);
		power_on_pulse <= 0;
		#1;
		wait_oe;
		len(0);
		chk(n, 4096);
		len(1);
		chk(n, 64);
		apb(0, `RCS_CAUSE_OFS, 0);
		chk(q, 32'h1 << `RCS_CAUSE_POR);
	endtask
	// ====================
	// Main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{power_on_pulse, brownout_in, watchdog_req, bad_opcode_in} = '0;
		{stop_exec, wait_exec, wake_event, opcode_fetch} = '0;
		{addr_unmapped, monitor_mode, break_state, hv_reset_pin} = '0;
		{hv_irq_pin, hold_low} = '0;
		presetn = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		#1;
		t_por;
		t_vec;
		t_wait;
		t_wdog(1);
		t_wdog(0);
		t_int;
		t_pin(40, 0);
		t_pin(80, 1);
		t_brown;
		t_stop(3'h3, 32);
		t_stop(3'h2, 4096);
		t_pwr;
		stop_test;
	end
endmodule
